/* File: pcg_channel.sv */
`timescale 1ns/1ns
module pcg_channel
    import pcg_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [PCG_NUM_CLK-1:0] clk_vec,
    input  wire pcg_chan_s              cfg,
    input  wire logic                   enable,
    output logic                        wave_out,
    output logic                        period_evt,
    output logic [15:0]                 count
);

    logic [15:0] cnt_ff;
    logic        wave_ff;
    logic        evt_ff;
    logic        sel_tick;
    logic        wrap;

    // [RQ8] per-channel clock choice
    assign sel_tick = (cfg.clk_sel < 4'(PCG_NUM_CLK)) ? clk_vec[cfg.clk_sel] : 1'b0;
    assign wrap     = (cfg.period == 16'h0000) || (cnt_ff >= cfg.period - 16'h0001);
    assign wave_out   = wave_ff;
    assign period_evt = evt_ff;
    assign count      = cnt_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 16'h0000;
            evt_ff <= 1'b0;
        end else begin
            evt_ff <= enable && sel_tick && wrap;
            if (enable && sel_tick) begin
                cnt_ff <= wrap ? 16'h0000 : cnt_ff + 16'h0001;
            end
        end
    end

    // [RQ9] one waveform per line
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_ff <= 1'b0;
        end else begin
            wave_ff <= enable ? ((cnt_ff < cfg.duty) ^ cfg.polarity) : cfg.polarity;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_CH_COUNTS_ON_OWN_CLOCK: assert property ( // [RQ8]
        !(enable && sel_tick) |=> $stable(cnt_ff))
        else $error("channel counter moved without its selected clock");

    AST_CH_WAVE_LEVEL: assert property ( // [RQ9]
        enable |=> wave_out == (($past(cnt_ff) < $past(cfg.duty)) ^ $past(cfg.polarity)))
        else $error("channel waveform level disagrees with counter");

endmodule

/* File: pcg_lin_div.sv */
`timescale 1ns/1ns
module pcg_lin_div
    import pcg_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [PCG_NUM_PRE-1:0] pre_tick,
    input  wire logic [3:0]             src_sel,
    input  wire logic [7:0]             factor,
    output logic                        tick_out
);

    logic [7:0] cnt_ff;
    logic       tick_ff;
    logic       src_tick;

    // [RQ14] reserved select
    assign src_tick = (src_sel <= PCG_PRE_MAX) ? pre_tick[src_sel] : 1'b0;
    assign tick_out = tick_ff;

    // [RQ5] divide by factor
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else if (factor == 8'h00) begin
            cnt_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else if (src_tick) begin
            if (cnt_ff >= factor - 8'h01) begin
                cnt_ff  <= 8'h00;
                tick_ff <= 1'b1;
            end else begin
                cnt_ff  <= cnt_ff + 8'h01;
                tick_ff <= 1'b0;
            end
        end else begin
            tick_ff <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_DIV_ONE_PASSES: assert property ( // [RQ3]
        (factor == 8'h01 && src_tick) |=> tick_out)
        else $error("divide by one did not pass source tick");

    AST_DIV_ZERO_STOPS: assert property ( // [RQ6]
        (factor == 8'h00) |=> !tick_out)
        else $error("divided clock ran with zero factor");

    AST_DIV_RESERVED_SEL: assert property ( // [RQ14]
        (src_sel > PCG_PRE_MAX) && $stable(src_sel) && $stable(factor) [*2] |=> !tick_out)
        else $error("divided clock ran on reserved source");

    sequence s_two_ticks_f2;
        (factor == 8'h02 && src_tick && cnt_ff == 8'h00) ##1 (!src_tick && factor == 8'h02)
            ##1 (src_tick && factor == 8'h02);
    endsequence

    AST_DIV_TWO_RATIO: assert property ( // [RQ5]
        s_two_ticks_f2 |=> tick_out)
        else $error("divide by two gave no tick on second source tick");

endmodule

/* File: pcg_load_model.sv */
`timescale 1ns/1ns
module pcg_load_model
    import pcg_pkg::*;
#(
    parameter int NCH = 4
)(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [NCH-1:0]        wave,
    output logic [NCH-1:0][15:0]       per,
    output logic [NCH-1:0][15:0]       rises
);
    logic [NCH-1:0][15:0] age_ff;
    logic [NCH-1:0]       prev_ff;

    always_ff @(posedge aclk) begin
        prev_ff <= wave;
        for (int i = 0; i < NCH; i++) begin
            if (!aresetn) begin
                age_ff[i] <= 16'h0;
                per[i] <= 16'h0;
                rises[i] <= 16'h0;
            end else if (wave[i] && !prev_ff[i]) begin
                per[i] <= age_ff[i] + 16'h1;
                age_ff[i] <= 16'h0;
                rises[i] <= rises[i] + 16'h1;
            end else begin
                age_ff[i] <= age_ff[i] + 16'h1;
            end
        end
    end
endmodule

/* File: pcg_pkg.sv */
package pcg_pkg;

    // Clock generator shape
    localparam int          PCG_NUM_PRE    = 11;
    localparam int          PCG_NUM_CLK    = 13;
    localparam logic [3:0]  PCG_PRE_MAX    = 4'ha;
    localparam logic [3:0]  PCG_SEL_A      = 4'hb;
    localparam logic [3:0]  PCG_SEL_B      = 4'hc;
    localparam int          PCG_PRE_W      = 10;

    // Register map (byte addresses)
    localparam int          PCG_ADDR_W     = 8;
    localparam logic [7:0]  PCG_OFF_MODE   = 8'h00;
    localparam logic [7:0]  PCG_OFF_ENABLE = 8'h04;
    localparam logic [7:0]  PCG_OFF_STATUS = 8'h08;
    localparam logic [7:0]  PCG_OFF_INTSTS = 8'h0c;
    localparam logic [7:0]  PCG_OFF_INTCLR = 8'h10;
    localparam logic [7:0]  PCG_OFF_INTEN  = 8'h14;
    localparam logic [7:0]  PCG_OFF_CH     = 8'h20;
    localparam int          PCG_CH_SHIFT   = 4;
    localparam logic [1:0]  PCG_CH_CFG     = 2'h0;
    localparam logic [1:0]  PCG_CH_PERIOD  = 2'h1;
    localparam logic [1:0]  PCG_CH_DUTY    = 2'h2;
    localparam logic [1:0]  PCG_CH_COUNT   = 2'h3;

    // Reset values and mode register write mask
    localparam logic [31:0] PCG_RST_MODE   = 32'h0000_0000;
    localparam logic [31:0] PCG_RST_WORD   = 32'h0000_0000;
    localparam logic [31:0] PCG_MODE_MASK  = 32'h0fff_0fff;

    // Bus responses
    localparam logic [1:0]  PCG_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  PCG_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [3:0] pad_hi;
        logic [3:0] divider_b_source_select;
        logic [7:0] divider_b_factor;
        logic [3:0] pad_lo;
        logic [3:0] divider_a_source_select;
        logic [7:0] divider_a_factor;
    } pcg_mode_s;

    typedef struct packed {
        logic [3:0]  clk_sel;
        logic        polarity;
        logic [15:0] period;
        logic [15:0] duty;
    } pcg_chan_s;

endpackage

/* File: pcg_top.sv */
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
// Summary of operation
// [RQ1] Runs on master clock and offers thirteen selectable clocks to channels.
// [RQ2] Power-of-two prescaler yields master clock and divisions by 2 up to 1024.
// [RQ3] Two independent linear dividers make clocks A and B, ratio 1 to 255.
// [RQ4] Each linear divider picks its own prescaler output by its select field.
// [RQ5] Divided clock rate is selected prescaler clock over divider factor.
// [RQ6] Reset zeroes selects and factors; zero factor keeps divided clock stopped.
// [RQ7] In reset or clock gating only the undivided master clock stays active.
// [RQ8] Each channel picks its own counting clock; attributes configured per channel.
// [RQ9] Each channel drives exactly one waveform on its own output line.
// [RQ10] Stopping and restarting unit clock keeps state and resumes where halted.
// [RQ11] Configuration registers accept writes while the unit clock is off.
// [RQ12] Software enables unit clock in power manager before expecting waveforms.
// [RQ13] Interrupt controller should treat the interrupt line as level sensitive.
// [RQ14] Select value n picks master clock over two to n; above ten reserved.
module pcg_top
    import pcg_pkg::*;
#(
    parameter int NCH = 4
)(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  unit_clock_enable,
    input  wire logic [PCG_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [PCG_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [NCH-1:0]             channel_waveform_out,
    output logic                       irq
);

    // Elaboration check on channel count
    if (NCH < 1 || NCH > 8) begin : g_bad_nch
        $error("NCH must lie between 1 and 8");
    end

    function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [3:0] chan_index(input logic [PCG_ADDR_W-1:0] addr);
        logic [PCG_ADDR_W-1:0] off;
        off = addr - PCG_OFF_CH;
        return off[PCG_CH_SHIFT +: 4];
    endfunction

    function automatic logic is_chan(input logic [PCG_ADDR_W-1:0] addr);
        return (addr >= PCG_OFF_CH) && (chan_index(addr) < 4'(NCH));
    endfunction

    // Bus slave state
    logic                  awready_ff;
    logic                  wready_ff;
    logic                  aw_full_ff;
    logic                  w_full_ff;
    logic [PCG_ADDR_W-1:0] awaddr_ff;
    logic [31:0]           wdata_ff;
    logic [3:0]            wstrb_ff;
    logic                  bvalid_ff;
    logic [1:0]            bresp_ff;
    logic                  arready_ff;
    logic                  rvalid_ff;
    logic [31:0]           rdata_ff;
    logic [1:0]            rresp_ff;
    logic                  wr_do;

    // Block state
    pcg_mode_s             waveform_mode_register;
    logic [NCH-1:0]        ch_en_ff;
    logic [NCH-1:0]        int_sts_ff;
    logic [NCH-1:0]        int_en_ff;
    logic                  irq_ff;
    pcg_chan_s             cfg_ff [NCH];
    logic [PCG_PRE_W-1:0]  pre_cnt_ff;
    logic [PCG_NUM_PRE-1:0] pre_tick;
    logic                  divided_clock_a;
    logic                  divided_clock_b;
    logic [PCG_NUM_CLK-1:0] clk_vec;
    logic [NCH-1:0]        period_evt;
    logic [15:0]           ch_count [NCH];
    logic [31:0]           rd_word;
    logic                  rd_ok;
    logic [NCH-1:0]        clr_mask;

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign irq           = irq_ff;

    assign wr_do = aw_full_ff && w_full_ff && !bvalid_ff;

    // Write address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            aw_full_ff <= 1'b0;
            awaddr_ff  <= '0;
        end else if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_full_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
        end else begin
            if (wr_do) begin
                aw_full_ff <= 1'b0;
            end
            awready_ff <= !aw_full_ff && !bvalid_ff && !wr_do;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_ff <= 1'b0;
            w_full_ff <= 1'b0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_full_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
        end else begin
            if (wr_do) begin
                w_full_ff <= 1'b0;
            end
            wready_ff <= !w_full_ff && !bvalid_ff && !wr_do;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= PCG_RESP_OKAY;
        end else if (wr_do) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (awaddr_ff <= PCG_OFF_INTEN || is_chan(awaddr_ff))
                         ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // [RQ11] writes are not gated by the unit clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waveform_mode_register <= PCG_RST_MODE;
            ch_en_ff  <= '0;
            int_en_ff <= '0;
            for (int i = 0; i < NCH; i++) begin
                cfg_ff[i] <= '0;
            end
        end else if (wr_do) begin
            if (awaddr_ff == PCG_OFF_MODE) begin
                waveform_mode_register <= merge_strb(waveform_mode_register, wdata_ff,
                                                     wstrb_ff) & PCG_MODE_MASK;
            end
            if (awaddr_ff == PCG_OFF_ENABLE && wstrb_ff[0]) begin
                ch_en_ff <= wdata_ff[NCH-1:0];
            end
            if (awaddr_ff == PCG_OFF_INTEN && wstrb_ff[0]) begin
                int_en_ff <= wdata_ff[NCH-1:0];
            end
            for (int i = 0; i < NCH; i++) begin
                if (is_chan(awaddr_ff) && chan_index(awaddr_ff) == 4'(i)) begin
                    unique case (awaddr_ff[3:2])
                        PCG_CH_CFG: begin
                            if (wstrb_ff[0]) cfg_ff[i].clk_sel  <= wdata_ff[3:0];
                            if (wstrb_ff[1]) cfg_ff[i].polarity <= wdata_ff[8];
                        end
                        PCG_CH_PERIOD: begin
                            cfg_ff[i].period <= 16'(merge_strb(32'(cfg_ff[i].period),
                                                               wdata_ff, wstrb_ff));
                        end
                        PCG_CH_DUTY: begin
                            cfg_ff[i].duty <= 16'(merge_strb(32'(cfg_ff[i].duty),
                                                             wdata_ff, wstrb_ff));
                        end
                        PCG_CH_COUNT: begin
                        end
                    endcase
                end
            end
        end
    end

    // Sticky period events; a new event beats a clear in the same cycle
    always_comb begin
        clr_mask = '0;
        if (wr_do && awaddr_ff == PCG_OFF_INTCLR && wstrb_ff[0]) begin
            clr_mask = wdata_ff[NCH-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_sts_ff <= '0;
            irq_ff     <= 1'b0;
        end else begin
            int_sts_ff <= (int_sts_ff & ~clr_mask) | period_evt;
            irq_ff     <= |(int_sts_ff & int_en_ff);
        end
    end

    // [RQ10] prescaler freezes while gated and resumes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_ff <= '0;
        end else if (unit_clock_enable) begin
            pre_cnt_ff <= pre_cnt_ff + 10'h001;
        end
    end

    // [RQ2] power-of-two ticks
    assign pre_tick[0] = unit_clock_enable;
    for (genvar k = 1; k < PCG_NUM_PRE; k++) begin : g_pre
        localparam logic [PCG_PRE_W-1:0] LOW_MASK = PCG_PRE_W'((1 << k) - 1);
        // [RQ7] only master clock outside run
        assign pre_tick[k] = unit_clock_enable && aresetn
                             && ((pre_cnt_ff & LOW_MASK) == LOW_MASK);
    end

    // [RQ4] independent source selects
    pcg_lin_div u_div_a (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pre_tick (pre_tick),
        .src_sel  (waveform_mode_register.divider_a_source_select),
        .factor   (waveform_mode_register.divider_a_factor),
        .tick_out (divided_clock_a)
    );

    pcg_lin_div u_div_b (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pre_tick (pre_tick),
        .src_sel  (waveform_mode_register.divider_b_source_select),
        .factor   (waveform_mode_register.divider_b_factor),
        .tick_out (divided_clock_b)
    );

    // [RQ1] thirteen clocks offered
    assign clk_vec = {divided_clock_b, divided_clock_a, pre_tick};

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        pcg_channel u_ch (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .clk_vec    (clk_vec),
            .cfg        (cfg_ff[c]),
            .enable     (ch_en_ff[c]),
            .wave_out   (channel_waveform_out[c]),
            .period_evt (period_evt[c]),
            .count      (ch_count[c])
        );
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        if (s_axi_araddr == PCG_OFF_MODE) begin
            rd_word = waveform_mode_register;
        end else if (s_axi_araddr == PCG_OFF_ENABLE) begin
            rd_word = 32'(ch_en_ff);
        end else if (s_axi_araddr == PCG_OFF_STATUS) begin
            rd_word = 32'({channel_waveform_out, 8'(unit_clock_enable)});
        end else if (s_axi_araddr == PCG_OFF_INTSTS) begin
            rd_word = 32'(int_sts_ff);
        end else if (s_axi_araddr == PCG_OFF_INTEN) begin
            rd_word = 32'(int_en_ff);
        end else if (s_axi_araddr == PCG_OFF_INTCLR) begin
            rd_word = PCG_RST_WORD;
        end else if (is_chan(s_axi_araddr)) begin
            for (int i = 0; i < NCH; i++) begin
                if (chan_index(s_axi_araddr) == 4'(i)) begin
                    unique case (s_axi_araddr[3:2])
                        PCG_CH_CFG:    rd_word = {23'h0, cfg_ff[i].polarity, 4'h0,
                                                  cfg_ff[i].clk_sel};
                        PCG_CH_PERIOD: rd_word = 32'(cfg_ff[i].period);
                        PCG_CH_DUTY:   rd_word = 32'(cfg_ff[i].duty);
                        PCG_CH_COUNT:  rd_word = 32'(ch_count[i]);
                    endcase
                end
            end
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= PCG_RESP_OKAY;
        end else if (s_axi_arvalid && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_word;
            rresp_ff   <= rd_ok ? PCG_RESP_OKAY : PCG_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff  <= 1'b0;
        end else if (!rvalid_ff) begin
            arready_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_GATED_ONLY_MASTER: assert property ( // [RQ7]
        !unit_clock_enable |-> (pre_tick[PCG_NUM_PRE-1:1] == '0))
        else $error("divided prescaler tick while unit clock gated");

    AST_PRE_HALVING: assert property ( // [RQ2]
        pre_tick[2] |-> pre_tick[1] ##1 !pre_tick[1] ##1 (!pre_tick[2] || !unit_clock_enable))
        else $error("prescaler stage ratio broken");

    AST_PRE_TOP_SPACING: assert property ( // [RQ2]
        pre_tick[10] |-> pre_cnt_ff == 10'h3ff)
        else $error("divide by 1024 tick at wrong count");

    AST_GATE_HOLDS_STATE: assert property ( // [RQ10]
        !unit_clock_enable |=> $stable(pre_cnt_ff))
        else $error("prescaler moved while unit clock gated");

    AST_MODE_WRITE_GATED: assert property ( // [RQ11]
        (wr_do && awaddr_ff == PCG_OFF_MODE && wstrb_ff == 4'hf && !unit_clock_enable)
        |=> waveform_mode_register == ($past(wdata_ff) & PCG_MODE_MASK))
        else $error("mode write lost while unit clock gated");

    AST_EVENT_TO_IRQ: assert property (
        (period_evt != '0) && ((period_evt & int_en_ff) != '0) |=> ##1 irq)
        else $error("enabled event did not raise interrupt");

endmodule

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench
    import pcg_pkg::*;
();
    logic             aclk, aresetn, ucen, irq;
    logic [7:0]       awaddr, araddr;
    logic [31:0]      wdata, rdata, rd_v;
    logic [3:0]       wstrb, wave;
    logic             awvalid, awready, wvalid, wready, bvalid, bready;
    logic             arvalid, arready, rvalid, rready;
    logic [1:0]       bresp, rresp;
    logic [3:0][15:0] per, rises;
    logic [15:0]      snap;
    int               miscompares, tests_run;
    int               cyc = 0;

    pcg_top #(.NCH(4)) pcg_top_inst (.aclk(aclk), .aresetn(aresetn),
        .unit_clock_enable(ucen), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .channel_waveform_out(wave), .irq(irq));

    pcg_load_model #(.NCH(4)) pcg_load_model_inst (.aclk(aclk), .aresetn(aresetn),
        .wave(wave), .per(per), .rises(rises));

    always #5 aclk = ~aclk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    task automatic test_done();
        $display("TB: miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 200);
        chk("bvalid", 32'h1, {31'h0, bvalid});
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 200);
        chk("rvalid", 32'h1, {31'h0, rvalid});
        rd_v = rdata;
        rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge aclk);
    endtask

    task automatic chan(input int c, input logic [3:0] s, input logic [15:0] p,
                        input logic [15:0] d);
        logic [7:0] b;
        b = PCG_OFF_CH + 8'(c * 16);
        wr(b, {28'h0, s}, PCG_RESP_OKAY);
        wr(b + 8'h4, {16'h0, p}, PCG_RESP_OKAY);
        wr(b + 8'h8, {16'h0, d}, PCG_RESP_OKAY);
    endtask

    // Period between rising edges once three fresh edges are seen
    task automatic meas(input int c, input logic [15:0] e);
        int n;
        n = 0;
        snap = rises[c];
        while (16'(rises[c] - snap) < 16'h3 && n < 8000) begin
            @(posedge aclk);
            n++;
        end
        chk("wave edges", 32'h3, {16'h0, 16'(rises[c] - snap)});
        chk("wave period", {16'h0, e}, {16'h0, per[c]});
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        ucen = 1'b0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hf;
        miscompares = 0;
        tests_run = 0;
        repeat (5) @(posedge aclk);
        chk("reset wave", 32'h0, {28'h0, wave});
        aresetn <= 1'b1;
        ucen <= 1'b1;
        @(posedge aclk);
        rd(PCG_OFF_MODE, PCG_RESP_OKAY);
        chk("mode", PCG_RST_MODE, rd_v);
        rd(8'h18, PCG_RESP_SLVERR);
        chk("unmapped", 32'h0, rd_v);
        wr(8'h18, 32'h1, PCG_RESP_SLVERR);
        wr(PCG_OFF_MODE, 32'h0b01_0102, PCG_RESP_OKAY);
        rd(PCG_OFF_MODE, PCG_RESP_OKAY);
        chk("mode", 32'h0b01_0102, rd_v);
        chan(0, 4'h0, 16'h4, 16'h2);
        chan(1, 4'h1, 16'h3, 16'h1);
        chan(2, PCG_SEL_A, 16'h2, 16'h1);
        chan(3, PCG_SEL_B, 16'h2, 16'h1);
        wr(PCG_OFF_INTEN, 32'h1, PCG_RESP_OKAY);
        wr(PCG_OFF_ENABLE, 32'hf, PCG_RESP_OKAY);
        meas(0, 16'h4);
        meas(1, 16'h6);
        meas(2, 16'h8);
        chk("reserved source b", 32'h1, {16'h0, rises[3]});
        repeat (5) @(posedge aclk);
        chk("irq level", 32'h1, {31'h0, irq});
        ucen <= 1'b0;
        repeat (3) @(posedge aclk);
        snap = rises[0];
        wr(PCG_OFF_INTCLR, 32'hf, PCG_RESP_OKAY);
        wr(PCG_OFF_CH + 8'h4, 32'h8, PCG_RESP_OKAY);
        wr(PCG_OFF_MODE, 32'hf000_f201, PCG_RESP_OKAY);
        rd(PCG_OFF_MODE, PCG_RESP_OKAY);
        chk("mode gated", 32'h0000_0201, rd_v);
        rd(PCG_OFF_INTSTS, PCG_RESP_OKAY);
        chk("status frozen", 32'h0, rd_v);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(PCG_OFF_STATUS, PCG_RESP_OKAY);
        chk("clock off", 32'h0, {31'h0, rd_v[0]});
        chk("wave frozen", {16'h0, snap}, {16'h0, rises[0]});
        wr(PCG_OFF_INTEN, 32'h0, PCG_RESP_OKAY);
        ucen <= 1'b1;
        meas(0, 16'h8);
        chk("stopped clock b", 32'h1, {16'h0, rises[3]});
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(PCG_OFF_INTSTS, PCG_RESP_OKAY);
        chk("sticky", 32'h1, {31'h0, rd_v[0]});
        chan(3, PCG_PRE_MAX, 16'h2, 16'h1);
        meas(3, 16'h800);
        test_done();
    end
endmodule
